// *** uie_pkg.sv ***
// Constants and types shared by the interrupt and line format block.
// Assumes a single 100 MHz clock domain and an 8-bit register port.
package uie_pkg;

	// =========================================================
	// Register port geometry and offsets
	localparam int        ADDR_W         = 3;
	localparam int        DATA_W         = 8;
	localparam logic [2:0] OFS_RX_TX      = 3'h0;
	localparam logic [2:0] OFS_MASK       = 3'h1;
	localparam logic [2:0] OFS_IDENT      = 3'h2;
	localparam logic [2:0] OFS_FORMAT     = 3'h3;
	localparam logic [2:0] OFS_LINE_STAT  = 3'h5;
	localparam logic [2:0] OFS_MODEM_STAT = 3'h6;

	// =========================================================
	// Interrupt mask fields and reset
	localparam int        MASK_W         = 4;
	localparam int        MASK_RX_BIT    = 0;
	localparam int        MASK_TRANSMIT_HOLDING_EMPTY_BIT  = 1;
	localparam int        MASK_LINE_BIT  = 2;
	localparam int        MASK_MODEM_BIT = 3;
	localparam logic [3:0] MASK_RST       = 4'h0;

	// =========================================================
	// Identification codes: source in bits 3..0, unused bits 5..4, flag field in bits 7..6
	localparam logic [3:0] ID_NONE        = 4'h1;
	localparam logic [3:0] ID_LINE        = 4'h6;
	localparam logic [3:0] ID_RX          = 4'h4;
	localparam logic [3:0] ID_TOUT        = 4'hc;
	localparam logic [3:0] ID_TRANSMIT_HOLDING_EMPTY        = 4'h2;
	localparam logic [3:0] ID_MODEM       = 4'h0;
	localparam logic [1:0] ID_FIFO_FLAGS  = 2'h3;
	localparam logic [1:0] ID_CHAR_FLAGS  = 2'h0;
	localparam logic [1:0] ID_UNUSED      = 2'h0;

	// =========================================================
	// Line format fields and reset
	localparam int        FMT_LEN_LSB    = 0;
	localparam int        FMT_STOP_BIT   = 2;
	localparam logic [7:0] FMT_RST        = 8'h00;
	localparam logic [3:0] FMT_MIN_BITS   = 4'h5;

	// =========================================================
	// FIFO control fields and reset
	localparam int        FC_EN_BIT      = 0;
	localparam int        FC_RX_CLR_BIT  = 1;
	localparam int        FC_TX_CLR_BIT  = 2;
	localparam int        FC_TRIG_LSB    = 6;
	localparam logic      FIFO_EN_RST    = 1'b0;
	localparam logic [1:0] TRIG_RST       = 2'h0;

	// =========================================================
	// Character timing, start and stop lengths counted in half-bit ticks
	localparam int        CNT_W          = 7;
	localparam logic [6:0] CHAR_TIMES_TOUT = 7'h04;
	localparam logic [6:0] START_HALVES   = 7'h02;
	localparam logic [2:0] STOP_ONE_HALVES  = 3'h2;
	localparam logic [2:0] STOP_ONEH_HALVES = 3'h3;
	localparam logic [2:0] STOP_TWO_HALVES  = 3'h4;
	localparam logic [1:0] RX_STOP_CHECKED  = 2'h1;

	// Reported interrupt source
	typedef enum logic [2:0] {
		SRC_NONE,
		SRC_LINE,
		SRC_RX,
		SRC_TOUT,
		SRC_TRANSMIT_HOLDING_EMPTY,
		SRC_MODEM
	} uie_src_e;

endpackage

// *** uie_tout_if.sv ***
// Link between the register block and the character time-out timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface uie_tout_if;
	logic       enable;
	logic       half_tick;
	logic       char_in;
	logic       rx_read;
	logic       nonempty;
	logic [1:0] len;
	logic       stop2;
	logic       timeout;

	modport ctrl (
		output enable,
		output half_tick,
		output char_in,
		output rx_read,
		output nonempty,
		output len,
		output stop2,
		input  timeout
	);

	modport timer (
		input  enable,
		input  half_tick,
		input  char_in,
		input  rx_read,
		input  nonempty,
		input  len,
		input  stop2,
		output timeout
	);
endinterface

// *** uie_char_timeout.sv ***
// Receive character time-out timer, four character times long.
// Assumes half_tick is a one-cycle pulse per half bit time.
`timescale 1ns/1ps
module uie_char_timeout
	import uie_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	// Control side
	uie_tout_if.timer tif
);
	import uie_pkg::*;

	typedef struct packed {
		logic [6:0] cnt;
		logic       fired;
	} uie_tmr_s;

	uie_tmr_s q;
	uie_tmr_s d;
	logic [6:0] limit;

	// Half-bit ticks in one character: start, data, generated stop bits
	function automatic logic [6:0] char_halves(input logic [1:0] len, input logic stop2);
		logic [2:0] stop;
		stop = STOP_ONE_HALVES;
		if (stop2) begin
			stop = (len == 2'h0) ? STOP_ONEH_HALVES : STOP_TWO_HALVES;
		end
		return START_HALVES + {1'h0, ({1'b0, FMT_MIN_BITS} + {3'h0, len}), 1'b0}
			+ {4'h0, stop};
	endfunction

	// [R8] four character times
	assign limit = 7'(CHAR_TIMES_TOUT * char_halves(tif.len, tif.stop2));

	always_comb begin
		d = q;
		if (!tif.enable || tif.rx_read) begin
			// [R20] read clears flag and timer
			d.cnt = '0;
			d.fired = 1'b0;
		end else if (!q.fired) begin
			if (tif.char_in || !tif.nonempty) begin
				d.cnt = '0;
			end else if (tif.half_tick) begin
				if (q.cnt == limit - 7'h01) begin
					// [R8] quiet FIFO times out
					d.fired = 1'b1;
					d.cnt = '0;
				end else begin
					d.cnt = q.cnt + 7'h01;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tif.timeout = q.fired;

endmodule

// *** uie_top.sv ***
// Interrupt enable, prioritised identification and line format registers.
// Assumes the receiver, transmitter, FIFOs and modem logic sit outside
// on the same clock and report events as one-cycle pulses.
`timescale 1ns/1ps

// How it works
// [R1] Mask bits 0..3 enable rx data, tx empty, line status, modem status.
// [R2] Mask bits 4..7 are not stored and read as zero.
// [R3] All four mask bits clear means no interrupt output at all.
// [R4] Line status, then rx data or time-out, then tx empty, then modem.
// [R5] Identification bit 0 is low while an interrupt is pending.
// [R6] Line status error reports 0110; reading line status clears it.
// [R7] Rx data available reports 0100; reading the receive buffer clears it.
// [R8] Four quiet character times with data waiting report 1100.
// [R9] Tx empty reports 0010; identification read or holding write clears.
// [R10] Modem input change reports 0000; reading modem status clears it.
// [R11] Bit 3 set only for time-out in FIFO mode.
// [R12] Identification bits 4 and 5 always read zero.
// [R13] Identification bits 6 and 7 follow the FIFO enable bit.
// [R14] The line format register reads back as written.
// [R15] Format bits 1:0 choose five to eight data bits.
// [R16] Format bit 2 gives one, one and a half, or two stop bits.
// [R17] The receiver checks only the first stop bit.
// [R18] FIFO enable bit selects FIFO mode for both directions.
// [R19] In FIFO mode rx data follows the trigger level reached.
// [R20] A receive read after time-out clears it and its timer.
// [R21] Interrupt output is high while any enabled source is pending.
// [R22] Host reads identification, clears the source, repeats until none.
module uie_top
	import uie_pkg::*;
(
	// Clock and reset
	input  wire logic                i_clk,
	input  wire logic                i_sys_rst,
	// Register port
	input  wire logic [ADDR_W-1:0]   i_addr,
	input  wire logic [DATA_W-1:0]   i_wdata,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output logic      [DATA_W-1:0]   o_rdata,
	// Status from the serial datapath
	input  wire logic [DATA_W-1:0]   i_rx_data,
	input  wire logic [DATA_W-1:0]   i_line_status,
	input  wire logic [DATA_W-1:0]   i_modem_status,
	input  wire logic                i_rx_avail,
	input  wire logic                i_line_err,
	input  wire logic                i_thr_empty,
	input  wire logic                i_modem_change,
	input  wire logic                i_rx_char_in,
	input  wire logic                i_rx_nonempty,
	input  wire logic                i_half_bit_tick,
	// Interrupt
	output logic                     o_interrupt_output,
	// Access pulses to the datapath
	output logic                     o_rx_buf_read,
	output logic                     o_tx_hold_write,
	output logic      [DATA_W-1:0]   o_tx_hold_data,
	output logic                     o_line_status_read,
	output logic                     o_modem_status_read,
	// FIFO control
	output logic                     o_fifo_mode,
	output logic                     o_rx_fifo_clear,
	output logic                     o_tx_fifo_clear,
	output logic      [1:0]          o_rx_trigger,
	// Line format
	output logic      [DATA_W-1:0]   o_format,
	output logic      [3:0]          o_data_bits,
	output logic      [2:0]          o_tx_stop_halves,
	output logic      [1:0]          o_rx_stop_checked
);
	import uie_pkg::*;

	// =========================================================
	// State

	typedef struct packed {
		logic [MASK_W-1:0] mask;
		logic [7:0]        fmt;
		logic              fifo_en;
		logic [1:0]        trig;
		logic              transmit_holding_empty;
		logic              line;
		logic              modem;
		logic [7:0]        rdata;
		logic              rx_rd;
		logic              tx_wr;
		logic [7:0]        tx_data;
		logic              ls_rd;
		logic              ms_rd;
		logic              rx_clr;
		logic              tx_clr;
		logic              irq;
	} uie_top_s;

	uie_top_s q;
	uie_top_s d;

	uie_tout_if tif ();

	logic       pend_line;
	logic       pend_rx;
	logic       pend_tout;
	logic       pend_transmit_holding_empty;
	logic       pend_modem;
	uie_src_e   src;
	logic [7:0] ident;
	logic       rd_rx;
	logic       rd_ident;
	logic       rd_line;
	logic       rd_modem;
	logic       wr_tx;

	// =========================================================
	// Helpers

	// Highest pending source wins
	function automatic uie_src_e pick_source(
		input logic line,
		input logic rx,
		input logic tout,
		input logic transmit_holding_empty,
		input logic modem
	);
		uie_src_e s;
		s = SRC_NONE;
		// [R4] fixed priority order
		if (line) begin
			s = SRC_LINE;
		end else if (tout) begin
			s = SRC_TOUT;
		end else if (rx) begin
			s = SRC_RX;
		end else if (transmit_holding_empty) begin
			s = SRC_TRANSMIT_HOLDING_EMPTY;
		end else if (modem) begin
			s = SRC_MODEM;
		end
		return s;
	endfunction

	// Source to identification code
	function automatic logic [3:0] source_code(input uie_src_e s);
		logic [3:0] c;
		case (s)
			SRC_LINE: begin
				c = ID_LINE;
			end
			SRC_RX: begin
				c = ID_RX;
			end
			SRC_TOUT: begin
				c = ID_TOUT;
			end
			SRC_TRANSMIT_HOLDING_EMPTY: begin
				c = ID_TRANSMIT_HOLDING_EMPTY;
			end
			SRC_MODEM: begin
				c = ID_MODEM;
			end
			default: begin
				c = ID_NONE;
			end
		endcase
		return c;
	endfunction

	// =========================================================
	// Strobe decode

	assign rd_rx    = i_rd && (i_addr == OFS_RX_TX);
	assign rd_ident = i_rd && (i_addr == OFS_IDENT);
	assign rd_line  = i_rd && (i_addr == OFS_LINE_STAT);
	assign rd_modem = i_rd && (i_addr == OFS_MODEM_STAT);
	assign wr_tx    = i_wr && (i_addr == OFS_RX_TX);

	// =========================================================
	// Time-out timer

	// [R18] timer only runs in FIFO mode
	assign tif.enable    = q.fifo_en;
	assign tif.half_tick = i_half_bit_tick;
	assign tif.char_in   = i_rx_char_in;
	assign tif.rx_read   = rd_rx;
	assign tif.nonempty  = i_rx_nonempty;
	assign tif.len       = q.fmt[FMT_LEN_LSB +: 2];
	assign tif.stop2     = q.fmt[FMT_STOP_BIT];

	uie_char_timeout u_tout (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.tif       (tif)
	);

	// =========================================================
	// Pending sources and identification

	// [R1] per-class enables
	// [R3] zero mask gates every class off
	assign pend_line  = q.line  && q.mask[MASK_LINE_BIT];
	// [R7] [R19] level from datapath, cleared by receive reads
	assign pend_rx    = i_rx_avail && q.mask[MASK_RX_BIT];
	// [R11] time-out only exists in FIFO mode
	assign pend_tout  = tif.timeout && q.fifo_en && q.mask[MASK_RX_BIT];
	assign pend_transmit_holding_empty  = q.transmit_holding_empty  && q.mask[MASK_TRANSMIT_HOLDING_EMPTY_BIT];
	assign pend_modem = q.modem && q.mask[MASK_MODEM_BIT];

	assign src = pick_source(pend_line, pend_rx, pend_tout, pend_transmit_holding_empty, pend_modem);

	always_comb begin
		ident = '0;
		// [R5] [R6] [R7] [R8] [R9] [R10] low nibble code
		ident[3:0] = source_code(src);
		// [R12] unused bits
		ident[5:4] = ID_UNUSED;
		// [R13] FIFO mode flags
		ident[7:6] = q.fifo_en ? ID_FIFO_FLAGS : ID_CHAR_FLAGS;
	end

	// =========================================================
	// Next state

	always_comb begin
		d = q;
		d.rx_rd  = rd_rx;
		d.tx_wr  = wr_tx;
		d.ls_rd  = rd_line;
		d.ms_rd  = rd_modem;
		d.rx_clr = 1'b0;
		d.tx_clr = 1'b0;
		d.rdata  = '0;

		if (wr_tx) begin
			d.tx_data = i_wdata;
		end

		if (i_wr) begin
			case (i_addr)
				OFS_MASK: begin
					// [R2] upper bits not stored
					d.mask = i_wdata[MASK_W-1:0];
				end
				OFS_IDENT: begin
					// [R18] FIFO enable; a change empties both FIFOs
					d.fifo_en = i_wdata[FC_EN_BIT];
					if (i_wdata[FC_EN_BIT] != q.fifo_en) begin
						d.rx_clr = 1'b1;
						d.tx_clr = 1'b1;
					end
					if (i_wdata[FC_EN_BIT]) begin
						d.rx_clr = d.rx_clr || i_wdata[FC_RX_CLR_BIT];
						d.tx_clr = d.tx_clr || i_wdata[FC_TX_CLR_BIT];
						d.trig   = i_wdata[FC_TRIG_LSB +: 2];
					end
				end
				OFS_FORMAT: begin
					d.fmt = i_wdata;
				end
				default: begin
					d.fmt = q.fmt;
				end
			endcase
		end

		if (i_rd) begin
			case (i_addr)
				OFS_RX_TX: begin
					d.rdata = i_rx_data;
				end
				OFS_MASK: begin
					// [R2] reads as zero above bit 3
					d.rdata = {4'h0, q.mask};
				end
				OFS_IDENT: begin
					d.rdata = ident;
				end
				OFS_FORMAT: begin
					// [R14] format reads back
					d.rdata = q.fmt;
				end
				OFS_LINE_STAT: begin
					d.rdata = i_line_status;
				end
				OFS_MODEM_STAT: begin
					d.rdata = i_modem_status;
				end
				default: begin
					d.rdata = '0;
				end
			endcase
		end

		// [R6] line status flag, set wins over read
		if (rd_line) begin
			d.line = 1'b0;
		end
		if (i_line_err) begin
			d.line = 1'b1;
		end

		// [R9] cleared by holding write or by reading it as source
		if (wr_tx || (rd_ident && src == SRC_TRANSMIT_HOLDING_EMPTY)) begin
			d.transmit_holding_empty = 1'b0;
		end
		if (i_thr_empty) begin
			d.transmit_holding_empty = 1'b1;
		end

		// [R10] modem change flag
		if (rd_modem) begin
			d.modem = 1'b0;
		end
		if (i_modem_change) begin
			d.modem = 1'b1;
		end

		// [R21] output tracks any enabled pending source
		d.irq = (src != SRC_NONE);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			q         <= '0;
			q.mask    <= MASK_RST;
			q.fmt     <= FMT_RST;
			q.fifo_en <= FIFO_EN_RST;
			q.trig    <= TRIG_RST;
		end else begin
			q <= d;
		end
	end

	// =========================================================
	// Outputs

	assign o_rdata             = q.rdata;
	assign o_interrupt_output  = q.irq;
	assign o_rx_buf_read       = q.rx_rd;
	assign o_tx_hold_write     = q.tx_wr;
	assign o_tx_hold_data      = q.tx_data;
	assign o_line_status_read  = q.ls_rd;
	assign o_modem_status_read = q.ms_rd;
	assign o_fifo_mode         = q.fifo_en;
	assign o_rx_fifo_clear     = q.rx_clr;
	assign o_tx_fifo_clear     = q.tx_clr;
	assign o_rx_trigger        = q.trig;
	assign o_format            = q.fmt;

	// [R15] data bits for both directions
	assign o_data_bits = FMT_MIN_BITS + {2'h0, q.fmt[FMT_LEN_LSB +: 2]};

	// [R16] generated stop length in half bits
	always_comb begin
		o_tx_stop_halves = STOP_ONE_HALVES;
		if (q.fmt[FMT_STOP_BIT]) begin
			o_tx_stop_halves = (q.fmt[FMT_LEN_LSB +: 2] == 2'h0)
				? STOP_ONEH_HALVES : STOP_TWO_HALVES;
		end
	end

	// [R17] receiver checks one stop bit
	assign o_rx_stop_checked = RX_STOP_CHECKED;

endmodule

// *** uie_monitor.sv ***
// Concurrent checks on the ports of the interrupt and line format block.
// Assumes one clock and a synchronous active-high reset; bound to uie_top.
`timescale 1ns/1ps
module uie_monitor
	import uie_pkg::*;
(
	// Clock and reset
	input wire logic                        i_clk,
	input wire logic                        i_sys_rst,
	// Register port
	input wire logic [uie_pkg::ADDR_W-1:0]  i_addr,
	input wire logic [uie_pkg::DATA_W-1:0]  i_wdata,
	input wire logic                        i_wr,
	input wire logic                        i_rd,
	input wire logic [uie_pkg::DATA_W-1:0]  o_rdata,
	// Block outputs
	input wire logic                        o_interrupt_output,
	input wire logic                        o_rx_buf_read,
	input wire logic                        o_modem_status_read,
	input wire logic                        o_rx_fifo_clear,
	input wire logic                        o_tx_fifo_clear,
	input wire logic [1:0]                  o_rx_trigger,
	input wire logic                        o_tx_hold_write,
	input wire logic [uie_pkg::DATA_W-1:0]  o_tx_hold_data,
	input wire logic                        o_line_status_read,
	input wire logic                        o_fifo_mode,
	input wire logic [uie_pkg::DATA_W-1:0]  o_format,
	input wire logic [3:0]                  o_data_bits,
	input wire logic [2:0]                  o_tx_stop_halves,
	input wire logic [1:0]                  o_rx_stop_checked
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// ==========================================================
	// Shadow of the mask as written by the host
	logic [3:0] mask_q;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			mask_q <= 4'h0;
		else if (i_wr && i_addr == OFS_MASK)
			mask_q <= i_wdata[3:0];
	end

	// ==========================================================
	// Assertions
	mask_off_a: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !o_interrupt_output)
		else $error("interrupt output high with mask clear");
	mask_read_a: assert property ($past(i_rd && i_addr == OFS_MASK)
		|-> o_rdata == {4'h0, $past(mask_q)})
		else $error("mask read back wrong");
	ident_high_a: assert property ($past(i_rd && i_addr == OFS_IDENT)
		|-> o_rdata[5:4] == 2'h0 && o_rdata[7:6] == {2{$past(o_fifo_mode)}})
		else $error("identification upper bits wrong");
	ident_bit3_a: assert property ($past(i_rd && i_addr == OFS_IDENT)
		|-> !o_rdata[3] || ($past(o_fifo_mode) && o_rdata[3:0] == ID_TOUT))
		else $error("identification bit 3 wrong");
	ident_pending_a: assert property ($past(i_rd && i_addr == OFS_IDENT)
		|-> o_rdata[0] == !o_interrupt_output)
		else $error("pending bit disagrees with interrupt output");
	fmt_write_a: assert property (i_wr && i_addr == OFS_FORMAT |=> o_format == $past(i_wdata))
		else $error("format write not stored");
	fmt_read_a: assert property ($past(i_rd && i_addr == OFS_FORMAT)
		|-> o_rdata == $past(o_format))
		else $error("format read back wrong");
	data_bits_a: assert property (o_data_bits == FMT_MIN_BITS + {2'h0, o_format[1:0]})
		else $error("data bit count wrong");
	stop_count_a: assert property (o_tx_stop_halves == (!o_format[2] ? STOP_ONE_HALVES :
		(o_format[1:0] == 2'h0 ? STOP_ONEH_HALVES : STOP_TWO_HALVES)))
		else $error("stop bit count wrong");
	rx_stop_a: assert property (o_rx_stop_checked == RX_STOP_CHECKED)
		else $error("receiver stop check count wrong");
	line_read_a: assert property (i_rd && i_addr == OFS_LINE_STAT |=> o_line_status_read)
		else $error("line status read pulse missing");
	hold_write_a: assert property (i_wr && i_addr == OFS_RX_TX
		|=> o_tx_hold_write && o_tx_hold_data == $past(i_wdata))
		else $error("holding write pulse or data wrong");
	rx_read_a: assert property (i_rd && i_addr == OFS_RX_TX |=> o_rx_buf_read)
		else $error("receive read pulse missing");
	modem_read_a: assert property (i_rd && i_addr == OFS_MODEM_STAT |=> o_modem_status_read)
		else $error("modem status read pulse missing");
	rx_clear_a: assert property (o_rx_fifo_clear == $past(i_wr && i_addr == OFS_IDENT
		&& (i_wdata[0] != o_fifo_mode || (i_wdata[0] && i_wdata[1]))))
		else $error("receive FIFO clear pulse wrong");
	tx_clear_a: assert property (o_tx_fifo_clear == $past(i_wr && i_addr == OFS_IDENT
		&& (i_wdata[0] != o_fifo_mode || (i_wdata[0] && i_wdata[2]))))
		else $error("transmit FIFO clear pulse wrong");
	trigger_set_a: assert property ($past(i_wr && i_addr == OFS_IDENT && i_wdata[0])
		|-> o_rx_trigger == $past(i_wdata[7:6]))
		else $error("trigger level not stored");

	tout_seen_c: cover property ($past(i_rd && i_addr == OFS_IDENT) && o_rdata[3:0] == ID_TOUT);
	int_rise_c: cover property ($rose(o_interrupt_output));
	fifo_on_c: cover property ($rose(o_fifo_mode));
endmodule

bind uie_top uie_monitor mon (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_interrupt_output(o_interrupt_output),
	.o_rx_buf_read(o_rx_buf_read), .o_modem_status_read(o_modem_status_read),
	.o_rx_fifo_clear(o_rx_fifo_clear), .o_tx_fifo_clear(o_tx_fifo_clear),
	.o_rx_trigger(o_rx_trigger),
	.o_tx_hold_write(o_tx_hold_write), .o_tx_hold_data(o_tx_hold_data),
	.o_line_status_read(o_line_status_read), .o_fifo_mode(o_fifo_mode),
	.o_format(o_format), .o_data_bits(o_data_bits), .o_tx_stop_halves(o_tx_stop_halves),
	.o_rx_stop_checked(o_rx_stop_checked)
);

// *** uie_host_model.sv ***
// Host processor model driving the register port of the block.
// Assumes the block never stalls and answers a read one cycle later.
`timescale 1ns/1ps
module uie_host_model
	import uie_pkg::*;
(
	// Clock
	input  wire logic                   i_clk,
	// Register port
	output logic [uie_pkg::ADDR_W-1:0]  o_addr,
	output logic [uie_pkg::DATA_W-1:0]  o_wdata,
	output logic                        o_wr,
	output logic                        o_rd
);
	initial begin
		o_addr = 3'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_wdata <= ~d;
	endtask

	task automatic rd_reg(input logic [2:0] a);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
	endtask
endmodule

// *** test_uie_top.sv ***
// Self-checking bench for the interrupt and line format block.
// Assumes the host model and the bound checker compile alongside.
`timescale 1ns/1ps
module test_uie_top;
	import uie_pkg::*;
	logic clk, rst, rx_avail, nonempty, tick, tick_en, rd_seen, wr, rd, intr, fifo_mode;
	logic [2:0] addr, stop;
	logic [3:0] ev, bits;
	logic [1:0] rx_stop;
	logic [7:0] wdata, rdata, rx_data, lsr, msr, f;
	logic [7:0] exp_q[$];
	int seed, checks, mismatches;

	uie_host_model host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	uie_top dut (
		.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_rx_data(rx_data), .i_line_status(lsr),
		.i_modem_status(msr), .i_rx_avail(rx_avail), .i_line_err(ev[0]),
		.i_thr_empty(ev[1]), .i_modem_change(ev[2]), .i_rx_char_in(ev[3]),
		.i_rx_nonempty(nonempty), .i_half_bit_tick(tick), .o_interrupt_output(intr),
		.o_rx_buf_read(), .o_tx_hold_write(), .o_tx_hold_data(), .o_line_status_read(),
		.o_modem_status_read(), .o_fifo_mode(fifo_mode), .o_rx_fifo_clear(),
		.o_tx_fifo_clear(), .o_rx_trigger(), .o_format(), .o_data_bits(bits),
		.o_tx_stop_halves(stop), .o_rx_stop_checked(rx_stop)
	);

	always #5 clk = ~clk;
	always @(posedge clk) tick <= tick_en & ~tick;

	// ==========================================================
	// Compare tasks and verdict
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [3:0] got, input logic [3:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic final_report;
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Read result watcher, oldest note first
	always @(posedge clk) begin
		if (rd_seen)
			cmp8(rdata, (exp_q.size() > 0) ? exp_q.pop_front() : ~rdata);
		rd_seen <= rd;
	end

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host.rd_reg(a);
	endtask

	task automatic ev_pulse(input logic [3:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
		@(posedge clk);
	endtask

	task automatic chk_int(input logic e);
		repeat (2) @(posedge clk);
		chk_out({3'h0, intr}, {3'h0, e});
	endtask

	initial begin
		#100000;
		mismatches++;
		final_report();
	end

	// ==========================================================
	// Scenarios
	initial begin
		seed = 77162;
		clk = 1'b0;
		rst = 1'b1;
		ev = 4'h0;
		{rx_avail, nonempty, tick_en} = 3'h0;
		rx_data = 8'($random(seed));
		lsr = 8'($random(seed));
		msr = 8'($random(seed));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd_chk(OFS_MASK, 8'h00);
		rd_chk(OFS_FORMAT, FMT_RST);
		rd_chk(OFS_IDENT, {4'h0, ID_NONE});
		rd_chk(3'h4, 8'h00);
		host.wr_reg(OFS_MASK, 8'hff);
		rd_chk(OFS_MASK, 8'h0f);
		$display("reset and mask test done");
		for (int i = 0; i < 8; i++) begin
			f = 8'($random(seed));
			f[2:0] = 3'(i);
			host.wr_reg(OFS_FORMAT, f);
			rd_chk(OFS_FORMAT, f);
			chk_out(bits, 4'h5 + {2'h0, f[1:0]});
			chk_out({1'b0, stop}, f[2] ? (f[1:0] == 2'h0 ? 4'h3 : 4'h4) : 4'h2);
		end
		chk_out({2'h0, rx_stop}, 4'h1);
		$display("format test done");
		ev_pulse(4'h4);
		chk_int(1'b1);
		rd_chk(OFS_IDENT, {4'h0, ID_MODEM});
		ev_pulse(4'h2);
		rd_chk(OFS_IDENT, {4'h0, ID_TRANSMIT_HOLDING_EMPTY});
		rd_chk(OFS_IDENT, {4'h0, ID_MODEM});
		rx_avail <= 1'b1;
		ev_pulse(4'h1);
		rd_chk(OFS_IDENT, {4'h0, ID_LINE});
		rd_chk(OFS_LINE_STAT, lsr);
		rd_chk(OFS_IDENT, {4'h0, ID_RX});
		rd_chk(OFS_RX_TX, rx_data);
		rx_avail <= 1'b0;
		rd_chk(OFS_IDENT, {4'h0, ID_MODEM});
		host.wr_reg(OFS_MASK, 8'h00);
		chk_int(1'b0);
		rd_chk(OFS_IDENT, {4'h0, ID_NONE});
		host.wr_reg(OFS_MASK, 8'h08);
		chk_int(1'b1);
		rd_chk(OFS_MODEM_STAT, msr);
		chk_int(1'b0);
		host.wr_reg(OFS_MASK, 8'h02);
		ev_pulse(4'h2);
		chk_int(1'b1);
		host.wr_reg(OFS_RX_TX, 8'h5a);
		chk_int(1'b0);
		$display("priority test done");
		host.wr_reg(OFS_FORMAT, 8'h00);
		host.wr_reg(OFS_IDENT, 8'h47);
		host.wr_reg(OFS_MASK, 8'h01);
		chk_out({3'h0, fifo_mode}, 4'h1);
		rd_chk(OFS_IDENT, 8'hc1);
		nonempty <= 1'b1;
		tick_en <= 1'b1;
		repeat (80) @(posedge clk);
		rd_chk(OFS_IDENT, 8'hc1);
		repeat (80) @(posedge clk);
		rd_chk(OFS_IDENT, 8'hcc);
		rd_chk(OFS_RX_TX, rx_data);
		rd_chk(OFS_IDENT, 8'hc1);
		tick_en <= 1'b0;
		nonempty <= 1'b0;
		host.wr_reg(OFS_IDENT, 8'h00);
		rd_chk(OFS_IDENT, 8'h01);
		$display("fifo time-out test done");
		repeat (3) @(posedge clk);
		final_report();
	end
endmodule
